// ### scs_defines.vh
`ifndef SCS_DEFINES_VH
`define SCS_DEFINES_VH

// ----------------------------------------
// Clock and resolution
// ----------------------------------------
`define SCS_CLK_MHZ      250
`define SCS_RES_BITS     18
`define SCS_FIFO_DEPTH   16

// ----------------------------------------
// Timing, in ns and derived cycles
// ----------------------------------------
// Aperture delay: least time, rounded up
`define SCS_APER_NS      2
`define SCS_APER_CYC     ((`SCS_APER_NS * `SCS_CLK_MHZ + 999) / 1000)
// One conversion clock period per bit trial
`define SCS_BIT_NS       40
`define SCS_BIT_CYC      ((`SCS_BIT_NS * `SCS_CLK_MHZ + 999) / 1000)
// Shortest start-to-start period at full rate
`define SCS_MAX_SPS      250000
`define SCS_PERIOD_NS    4000
`define SCS_PERIOD_CYC   (`SCS_PERIOD_NS * `SCS_CLK_MHZ / 1000)
`define SCS_CNT_W        8

// ----------------------------------------
// Result codes, two's complement
// ----------------------------------------
`define SCS_CODE_MID     18'h00000
`define SCS_CODE_MID_M1  18'h3ffff
`define SCS_CODE_POS_FS  18'h1ffff
`define SCS_CODE_NEG_FS  18'h20000

`endif

// ### scs_sar_sequencer.v
// How it works
// - Host rising start edge ends acquisition, starts conversion
// - Input held a fixed aperture delay after edge
// - Open ground switches first, then ground arrays
// - Eighteen decisions, MSB first, matched arrays
// - Each trial switches one element ground-to-reference
// - After last bit: acquire, emit code, drop busy
// - Internal conversion clock times all trials
// - Supports up to 250k conversions per second
// - Powered down between conversions
// - Result belongs to its own conversion
// - Two's complement coding, midscale is zero
// - Overrange saturates to most positive code
// - Underrange saturates to most negative code
`include "scs_defines.vh"
`default_nettype none

// ----------------------------------------
// Wrapping pointer
// ----------------------------------------
module scs_ptr #(
   parameter AW = 4
) (
   input  wire        ref_clk_in,
   input  wire        srst_in,
   input  wire        inc_in,
   output reg  [AW:0] ptr_out
);
   // Extra top bit tells full from empty
   always @(posedge ref_clk_in) begin
      if (srst_in) begin
         ptr_out <= {(AW+1){1'b0}};
      end else if (inc_in) begin
         ptr_out <= ptr_out + 1'b1;
      end
   end
endmodule // scs_ptr

// ----------------------------------------
// Result FIFO
// ----------------------------------------
module scs_fifo #(
   parameter W = 18,
   parameter D = 16
) (
   input  wire         ref_clk_in,
   input  wire         srst_in,
   input  wire         wr_valid_in,
   output wire         wr_ready_out,
   input  wire [W-1:0] wr_data_in,
   output wire         rd_valid_out,
   input  wire         rd_ready_in,
   output wire [W-1:0] rd_data_out
);
   localparam AW = $clog2(D);

   reg [W-1:0] mem [0:D-1];
   wire [AW:0] wr_ptr_q;
   wire [AW:0] rd_ptr_q;
   wire        full;
   wire        empty;
   wire        do_wr;
   wire        do_rd;

   assign full  = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                  (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
   assign empty = (wr_ptr_q == rd_ptr_q);
   assign wr_ready_out = !full;
   assign rd_valid_out = !empty;
   assign do_wr = wr_valid_in && !full;
   assign do_rd = rd_ready_in && !empty;
   // Memory read is combinational, straight from the array word itself
   assign rd_data_out = mem[rd_ptr_q[AW-1:0]];

   always @(posedge ref_clk_in) begin
      if (do_wr) begin
         mem[wr_ptr_q[AW-1:0]] <= wr_data_in;
      end
   end

   scs_ptr #(
      .AW (AW)
   ) wr_ptr_i (
      .ref_clk_in (ref_clk_in),
      .srst_in    (srst_in),
      .inc_in     (do_wr),
      .ptr_out    (wr_ptr_q)
   );

   scs_ptr #(
      .AW (AW)
   ) rd_ptr_i (
      .ref_clk_in (ref_clk_in),
      .srst_in    (srst_in),
      .inc_in     (do_rd),
      .ptr_out    (rd_ptr_q)
   );
endmodule // scs_fifo

// ----------------------------------------
// Conversion sequencer
// ----------------------------------------
module scs_sar_sequencer #(
   parameter RES        = `SCS_RES_BITS,
   parameter FIFO_DEPTH = `SCS_FIFO_DEPTH,
   parameter APER_CYC   = `SCS_APER_CYC,
   parameter BIT_CYC    = `SCS_BIT_CYC
) (
   input  wire           ref_clk_in,
   input  wire           srst_in,
   input  wire           convert_start_input_in,
   output wire           start_ready_out,
   input  wire           comp_in,
   output reg            hold_out,
   output reg            input_connect_out,
   output reg            array_ground_out,
   output reg            positive_array_ground_switch_out,
   output reg            negative_array_ground_switch_out,
   output reg  [RES-1:0] pos_array_ref_out,
   output reg  [RES-1:0] neg_array_ref_out,
   output reg            power_up_out,
   output reg            busy_out,
   output wire           result_valid_out,
   input  wire           result_ready_in,
   output wire [RES-1:0] result_data_out
);
   localparam [5:0] ST_ACQ   = 6'h01;
   localparam [5:0] ST_APER  = 6'h02;
   localparam [5:0] ST_SWOPN = 6'h04;
   localparam [5:0] ST_GND   = 6'h08;
   localparam [5:0] ST_TRIAL = 6'h10;
   localparam [5:0] ST_DONE  = 6'h20;
   localparam CW = `SCS_CNT_W;
   localparam IW = $clog2(RES);

   reg  [5:0]     state_q;
   reg  [5:0]     state_d;
   reg  [CW-1:0]  cnt_q;
   reg  [CW-1:0]  cnt_d;
   reg  [IW-1:0]  idx_q;
   reg  [IW-1:0]  idx_d;
   reg  [RES-1:0] trial_q;
   reg  [RES-1:0] trial_d;
   reg            start_prev_q;
   reg            push;
   wire           start_edge;
   wire           conv_tick;
   wire           fifo_ready;
   wire [RES-1:0] twos_code;
   wire [31:0]    aper_m1;
   wire [31:0]    bit_m1;
   wire [31:0]    msb_m1;
   wire [CW-1:0]  aper_ld;
   wire [CW-1:0]  bit_ld;
   wire [IW-1:0]  msb_idx;

   // ----------------------------------------
   // Load values cut to counter width
   // ----------------------------------------
   // Counts above the counter width would wrap; keep parameters small
   assign aper_m1 = APER_CYC - 1;
   assign bit_m1  = BIT_CYC - 1;
   assign msb_m1  = RES - 1;
   assign aper_ld = aper_m1[CW-1:0];
   assign bit_ld  = bit_m1[CW-1:0];
   assign msb_idx = msb_m1[IW-1:0];

   // ----------------------------------------
   // Start edge and acceptance
   // ----------------------------------------
   always @(posedge ref_clk_in) begin
      if (srst_in) begin
         start_prev_q <= 1'b0;
      end else begin
         start_prev_q <= convert_start_input_in;
      end
   end

   assign start_edge = convert_start_input_in && !start_prev_q;
   // Refuse a start with no room, so no result is ever dropped
   assign start_ready_out = (state_q == ST_ACQ) && fifo_ready;

   // ----------------------------------------
   // Conversion clock divider
   // ----------------------------------------
   // Counter only runs out of acquisition, so it idles with the core
   assign conv_tick = (cnt_q == {CW{1'b0}});

   // Offset binary to two's complement; extremes clip naturally
   assign twos_code = {~trial_q[RES-1], trial_q[RES-2:0]};

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always @* begin
      state_d = state_q;
      cnt_d   = cnt_q;
      idx_d   = idx_q;
      trial_d = trial_q;
      push    = 1'b0;
      case (state_q)
         ST_ACQ: begin
            // Edges while busy never reach here
            if (start_edge && fifo_ready) begin
               state_d = ST_APER;
               cnt_d   = aper_ld;
            end
         end
         ST_APER: begin
            if (conv_tick) begin
               state_d = ST_SWOPN;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         ST_SWOPN: begin
            state_d = ST_GND;
         end
         ST_GND: begin
            state_d = ST_TRIAL;
            idx_d   = msb_idx;
            trial_d = {1'b1, {(RES-1){1'b0}}};
            cnt_d   = bit_ld;
         end
         ST_TRIAL: begin
            if (conv_tick) begin
               // Comparator low means the trial overshot
               if (!comp_in) begin
                  trial_d[idx_q] = 1'b0;
               end
               if (idx_q == {IW{1'b0}}) begin
                  state_d = ST_DONE;
               end else begin
                  idx_d = idx_q - 1'b1;
                  trial_d[idx_q - 1'b1] = 1'b1;
                  cnt_d = bit_ld;
               end
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         ST_DONE: begin
            push    = 1'b1;
            state_d = ST_ACQ;
         end
         default: begin
            state_d = ST_ACQ;
         end
      endcase
   end

   // ----------------------------------------
   // State registers
   // ----------------------------------------
   always @(posedge ref_clk_in) begin
      if (srst_in) begin
         state_q <= ST_ACQ;
         cnt_q   <= {CW{1'b0}};
         idx_q   <= {IW{1'b0}};
         trial_q <= {RES{1'b0}};
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         idx_q   <= idx_d;
         trial_q <= trial_d;
      end
   end

   // ----------------------------------------
   // Analogue controls, all registered
   // ----------------------------------------
   always @(posedge ref_clk_in) begin
      if (srst_in) begin
         hold_out                         <= 1'b0;
         input_connect_out                <= 1'b1;
         array_ground_out                 <= 1'b0;
         positive_array_ground_switch_out <= 1'b1;
         negative_array_ground_switch_out <= 1'b1;
         pos_array_ref_out                <= {RES{1'b0}};
         neg_array_ref_out                <= {RES{1'b0}};
         power_up_out                     <= 1'b0;
         busy_out                         <= 1'b0;
      end else begin
         case (state_d)
            ST_ACQ: begin
               // Track again, core asleep until next start
               hold_out                         <= 1'b0;
               input_connect_out                <= 1'b1;
               array_ground_out                 <= 1'b0;
               positive_array_ground_switch_out <= 1'b1;
               negative_array_ground_switch_out <= 1'b1;
               pos_array_ref_out                <= {RES{1'b0}};
               neg_array_ref_out                <= {RES{1'b0}};
               power_up_out                     <= 1'b0;
               busy_out                         <= 1'b0;
            end
            ST_APER: begin
               power_up_out <= 1'b1;
               busy_out     <= 1'b1;
            end
            ST_SWOPN: begin
               hold_out                         <= 1'b1;
               positive_array_ground_switch_out <= 1'b0;
               negative_array_ground_switch_out <= 1'b0;
            end
            ST_GND: begin
               // Only after the switches opened a cycle ago
               input_connect_out <= 1'b0;
               array_ground_out  <= 1'b1;
            end
            ST_TRIAL: begin
               pos_array_ref_out <= trial_d;
               neg_array_ref_out <= ~trial_d;
            end
            ST_DONE: begin
               pos_array_ref_out <= trial_d;
               neg_array_ref_out <= ~trial_d;
            end
            default: begin
               power_up_out <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Result buffer
   // ----------------------------------------
   // Start to push is far below the 4 us full-rate period
   scs_fifo #(
      .W (RES),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_in   (ref_clk_in),
      .srst_in      (srst_in),
      .wr_valid_in  (push),
      .wr_ready_out (fifo_ready),
      .wr_data_in   (twos_code),
      .rd_valid_out (result_valid_out),
      .rd_ready_in  (result_ready_in),
      .rd_data_out  (result_data_out)
   );
endmodule // scs_sar_sequencer

`default_nettype wire

// ### scs_sar_monitor.sv
`default_nettype none
module scs_sar_monitor #(
   parameter RES = 18
) (
   input wire logic           ref_clk_in,
   input wire logic           srst_in,
   input wire logic           convert_start_input_in,
   input wire logic           start_ready_out,
   input wire logic           hold_out,
   input wire logic           input_connect_out,
   input wire logic           array_ground_out,
   input wire logic           positive_array_ground_switch_out,
   input wire logic           negative_array_ground_switch_out,
   input wire logic [RES-1:0] pos_array_ref_out,
   input wire logic [RES-1:0] neg_array_ref_out,
   input wire logic           power_up_out,
   input wire logic           busy_out,
   input wire logic           result_valid_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);
   // ----
   // Conversion steps
   // ----
   sequence arrays_grounded;
      !input_connect_out && array_ground_out;
   endsequence
   sequence conv_done;
      ##[30:60] $fell(busy_out);
   endsequence
   start_taken_a: assert property (
      $rose(convert_start_input_in) && start_ready_out |=> busy_out)
      else $error("start edge not taken");
   busy_refuse_a: assert property (
      busy_out |-> !start_ready_out)
      else $error("start accepted while busy");
   aperture_hold_a: assert property (
      $rose(busy_out) |-> !hold_out ##1 hold_out)
      else $error("hold not one cycle after busy");
   switch_order_a: assert property (
      $fell(positive_array_ground_switch_out) |-> input_connect_out ##1 arrays_grounded)
      else $error("array switch order");
   switch_pair_a: assert property (
      positive_array_ground_switch_out == negative_array_ground_switch_out)
      else $error("ground switches differ");
   msb_first_a: assert property (
      $rose(array_ground_out) |=> pos_array_ref_out == {1'b1, {(RES-1){1'b0}}})
      else $error("first trial not msb");
   matched_arrays_a: assert property (
      array_ground_out && $past(array_ground_out) |-> neg_array_ref_out == ~pos_array_ref_out)
      else $error("arrays not matched");
   power_down_a: assert property (
      !busy_out |-> !power_up_out)
      else $error("powered while idle");
   back_acquire_a: assert property (
      $fell(busy_out) |-> result_valid_out && !hold_out && positive_array_ground_switch_out)
      else $error("no return to acquire");
   conv_time_a: assert property (
      $rose(busy_out) |-> conv_done)
      else $error("conversion length wrong");
endmodule // scs_sar_monitor

bind scs_sar_sequencer scs_sar_monitor #(.RES(RES)) scs_sar_monitor_i (.ref_clk_in,
   .srst_in, .convert_start_input_in, .start_ready_out, .hold_out, .input_connect_out,
   .array_ground_out, .positive_array_ground_switch_out, .negative_array_ground_switch_out,
   .pos_array_ref_out,
   .neg_array_ref_out, .power_up_out, .busy_out, .result_valid_out);
`default_nettype wire

// ### scs_comp_model.sv
`default_nettype none
module scs_comp_model (
   input wire logic        ref_clk_in,
   input wire logic        hold_in,
   input wire logic [17:0] trial_in,
   input wire logic [17:0] vin_in,
   output logic            comp_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [17:0] vin_q = 18'h00000;
   logic        idle_q = 1'b0;
   // ----
   // Sample and compare
   // ----
   // Tracks until held, so later input changes cannot leak in
   always @(posedge ref_clk_in) begin
      if (!hold_in) begin
         vin_q <= vin_in;
         idle_q <= ~idle_q;
      end
   end
   // Meaningless toggling outside a conversion
   assign comp_out = hold_in ? (vin_q >= trial_in) : idle_q;
endmodule // scs_comp_model
`default_nettype wire

// ### tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, srst = 1'b1, start = 1'b0, ready = 1'b0, comp, hold, busy, pwr;
   logic sready, rvalid;
   logic [17:0] vin = 18'h00000, pref, rdata;
   int num_errors = 0, samples_checked = 0;
   always #2 clk = ~clk;
   scs_sar_sequencer #(.APER_CYC(1), .BIT_CYC(2)) scs_sar_sequencer_i (.ref_clk_in(clk),
      .srst_in(srst), .convert_start_input_in(start), .start_ready_out(sready),
      .comp_in(comp), .hold_out(hold), .input_connect_out(), .array_ground_out(),
      .positive_array_ground_switch_out(), .negative_array_ground_switch_out(),
      .pos_array_ref_out(pref), .neg_array_ref_out(), .power_up_out(pwr),
      .busy_out(busy), .result_valid_out(rvalid), .result_ready_in(ready),
      .result_data_out(rdata));
   scs_comp_model scs_comp_model_i (.ref_clk_in(clk), .hold_in(hold), .trial_in(pref),
      .vin_in(vin), .comp_out(comp));
   // ----
   // Shared tasks
   // ----
   task chk(input logic [17:0] got, input logic [17:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task stop_test;
      if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task start_conv(input logic [17:0] v);
      @(posedge clk) #1;
      vin = v;
      start = 1'b1;
      repeat (2) @(posedge clk);
      #1 start = 1'b0;
   endtask
   task wait_idle;
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 200) begin
         @(posedge clk) #1;
         n++;
      end
      chk({17'h0, busy}, 18'h0);
   endtask
   task pop(input logic [17:0] exp);
      chk({17'h0, rvalid}, 18'h1);
      chk(rdata, exp);
      ready = 1'b1;
      @(posedge clk) #1 ready = 1'b0;
      @(posedge clk) #1;
   endtask
   // ----
   // Scenarios
   // ----
   task t_reset;
      chk({busy, pwr, sready}, 18'h1);
   endtask
   task t_codes;
      logic [17:0] v[7] = '{18'h3ffff, 18'h00000, 18'h20000, 18'h1ffff, 18'h20001,
                            18'h00001, 18'h2a5a5};
      logic [17:0] e[7] = '{18'h1ffff, 18'h20000, 18'h00000, 18'h3ffff, 18'h00001,
                            18'h20001, 18'h0a5a5};
      for (int i = 0; i < 7; i++) begin
         start_conv(v[i]);
         wait_idle;
         pop(e[i]);
      end
   endtask
   task t_ignore;
      start_conv(18'h35555);
      repeat (4) @(posedge clk) #1;
      vin = 18'h0aaaa;
      start = 1'b1;
      @(posedge clk) #1 start = 1'b0;
      chk({busy, sready}, 18'h2);
      wait_idle;
      pop(18'h15555);
      chk({17'h0, rvalid}, 18'h0);
   endtask
   task t_full;
      for (int i = 0; i < 16; i++) begin
         start_conv(18'h20000 + 18'(i));
         wait_idle;
      end
      chk({17'h0, sready}, 18'h0);
      start_conv(18'h3ffff);
      chk({17'h0, busy}, 18'h0);
      for (int i = 0; i < 16; i++) pop(18'(i));
      chk({17'h0, rvalid}, 18'h0);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      #1 srst = 1'b0;
      t_reset;
      t_codes;
      t_ignore;
      t_full;
      stop_test;
   end
   // Runs take about 4 us; allow a wide margin
   initial begin
      #50000;
      num_errors++;
      stop_test;
   end
endmodule // tb_top
`default_nettype wire
